// >>> rcc_pkg.sv
// Constants and types for the rate converter control and interrupt routing bank.
// Assumes a 40 MHz master clock and a plain address/strobe register port.
package rcc_pkg;

  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int BUS_W = 32;
  localparam int REG_W = 24;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] IER_OFS = 8'h04;
  localparam logic [7:0] IEM_OFS = 8'h08;
  localparam logic [7:0] IDHI_OFS = 8'h0c;
  localparam logic [7:0] IDLO_OFS = 8'h10;
  localparam logic [7:0] SRC_OFS = 8'h14;
  localparam logic [7:0] REQ_OFS = 8'h18;

  // Control register field positions
  localparam int CONV_EN_BIT = 0;
  localparam int PAIR_A_EN_BIT = 1;
  localparam int PAIR_B_EN_BIT = 2;
  localparam int PAIR_C_EN_BIT = 3;
  localparam int SOFT_RESET_TRIGGER_BIT = 4;
  localparam int IDEAL_SEL_A_BIT = 13;
  localparam int USE_RATIO_A_BIT = 14;

  // Interrupt source positions, shared by enable and routing registers
  localparam int IRQ_IN_A = 0;
  localparam int IRQ_IN_B = 1;
  localparam int IRQ_IN_C = 2;
  localparam int IRQ_OUT_A = 3;
  localparam int IRQ_OUT_B = 4;
  localparam int IRQ_OUT_C = 5;
  localparam int IRQ_OVERLOAD = 6;
  localparam int IRQ_WAIT = 7;
  localparam int IRQ_SRC_N = 8;

  // Ideal ratio register widths
  localparam int IDLO_W = 24;
  localparam int IDHI_W = 8;

  // Reset values and writable masks
  localparam logic [REG_W-1:0] CTRL_RST = 24'h000000;
  localparam logic [REG_W-1:0] IER_RST = 24'h000000;
  localparam logic [REG_W-1:0] IEM_RST = 24'h000000;
  localparam logic [REG_W-1:0] IDHI_RST = 24'h000000;
  localparam logic [REG_W-1:0] IDLO_RST = 24'h000000;
  localparam logic [REG_W-1:0] CTRL_WMASK = 24'h00600f;
  localparam logic [REG_W-1:0] IRQ_WMASK = 24'h0000ff;

  // Soft reset length in master clock cycles
  localparam int SOFT_RESET_TRIGGER_CYCLES = 9;
  localparam int SOFT_RESET_TRIGGER_CNT_W = 4;

  typedef enum logic [1:0] {
    SR_IDLE = 2'b01,
    SR_BUSY = 2'b10
  } rcc_soft_reset_trigger_state_t;

  typedef enum logic [2:0] {
    RS_OFF = 3'b001,
    RS_MEASURED = 3'b010,
    RS_IDEAL = 3'b100
  } rcc_ratio_src_t;

endpackage : rcc_pkg

// >>> rcc_soft_reset.sv
// Self-timed soft reset sequencer for the rate converter.
// Assumes start_i is a one-cycle request synchronous to clk_sys_i.
`timescale 1ns/1ps
module rcc_soft_reset
  import rcc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);

  rcc_soft_reset_trigger_state_t state_reg;
  logic [SOFT_RESET_TRIGGER_CNT_W-1:0] cnt_reg;

  // A start while busy is ignored, so the pulse never stretches
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= SR_IDLE;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        SR_IDLE: begin
          if (start_i) begin
            state_reg <= SR_BUSY;
            cnt_reg <= SOFT_RESET_TRIGGER_CNT_W'(SOFT_RESET_TRIGGER_CYCLES - 1);
          end
        end
        SR_BUSY: begin
          if (cnt_reg == '0) begin
            state_reg <= SR_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= SR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= (state_reg == SR_BUSY) && (cnt_reg == '0);
    end
  end

  assign busy_o = (state_reg == SR_BUSY);

endmodule : rcc_soft_reset

// >>> rcc_ctrl_irq.sv
// Control, ratio selection and interrupt routing bank of a three-pair
// rate converter. Assumes a register port with one-cycle strobes and
// level interrupt sources from the conversion datapath.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module rcc_ctrl_irq
  import rcc_pkg::*;
#(
  parameter int RATIO_W = 32
)
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [BUS_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [BUS_W-1:0] reg_rdata_o,
  input wire logic [RATIO_W-1:0] measured_ratio_a_i,
  input wire logic [IRQ_SRC_N-1:0] irq_src_i,
  output logic converter_enable_o,
  output logic pair_a_enable_o,
  output logic pair_b_enable_o,
  output logic pair_c_enable_o,
  output logic soft_rst_o,
  output logic [2:0] ratio_a_src_o,
  output logic [RATIO_W-1:0] ratio_a_o,
  output logic irq_core1_o,
  output logic irq_core2_o
);

  // Register storage
  logic [REG_W-1:0] ctrl_reg;
  logic [REG_W-1:0] ier_reg;
  logic [REG_W-1:0] iem_reg;
  logic [IDHI_W-1:0] ideal_ratio_high_a_reg;
  logic [IDLO_W-1:0] ideal_ratio_low_a_reg;
  logic [BUS_W-1:0] rdata_reg;
  logic [BUS_W-1:0] rdata_next;

  // Named control fields
  logic converter_enable;
  logic pair_a_enable;
  logic pair_b_enable;
  logic pair_c_enable;
  logic use_ratio_a;
  logic ideal_ratio_sel_a;

  // Decoded strobes
  logic wr_ctrl;
  logic wr_ier;
  logic wr_iem;
  logic wr_idhi;
  logic wr_idlo;

  // Soft reset sequencer handshake
  logic soft_reset_trigger_start;
  logic soft_reset_trigger_busy;
  logic soft_reset_trigger_done;

  // Ratio selection
  rcc_ratio_src_t ratio_src_next;
  logic [RATIO_W-1:0] ratio_next;
  logic [RATIO_W-1:0] ideal_ratio_a;
  rcc_ratio_src_t ratio_src_reg;
  logic [RATIO_W-1:0] ratio_reg;

  // Interrupt routing
  logic [IRQ_SRC_N-1:0] irq_gated;
  logic [IRQ_SRC_N-1:0] irq_to_core1;
  logic [IRQ_SRC_N-1:0] irq_to_core2;
  logic irq_core1_reg;
  logic irq_core2_reg;

  assign converter_enable = ctrl_reg[CONV_EN_BIT];
  assign pair_a_enable = ctrl_reg[PAIR_A_EN_BIT];
  assign pair_b_enable = ctrl_reg[PAIR_B_EN_BIT];
  assign pair_c_enable = ctrl_reg[PAIR_C_EN_BIT];
  assign use_ratio_a = ctrl_reg[USE_RATIO_A_BIT];
  assign ideal_ratio_sel_a = ctrl_reg[IDEAL_SEL_A_BIT];

  // Address decode for writes
  assign wr_ctrl = reg_wr_i && (reg_addr_i == CTRL_OFS);
  assign wr_ier = reg_wr_i && (reg_addr_i == IER_OFS);
  assign wr_iem = reg_wr_i && (reg_addr_i == IEM_OFS);
  assign wr_idhi = reg_wr_i && (reg_addr_i == IDHI_OFS);
  assign wr_idlo = reg_wr_i && (reg_addr_i == IDLO_OFS);

  // A one written to the soft reset bit launches the sequence
  assign soft_reset_trigger_start = wr_ctrl && reg_wdata_i[SOFT_RESET_TRIGGER_BIT];

  rcc_soft_reset u_soft_reset (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .start_i(soft_reset_trigger_start),
    .busy_o(soft_reset_trigger_busy),
    .done_o(soft_reset_trigger_done)
  );

  // Control register. The soft reset bit is not stored here: it reads
  // back from the sequencer, so it clears itself when the count ends.
  // Soft reset does not touch this bank, otherwise software could not
  // keep its configuration across a datapath restart.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ctrl) begin
      // Reserved and out-of-scope bits are dropped on write
      ctrl_reg <= reg_wdata_i[REG_W-1:0] & CTRL_WMASK;
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ier_reg <= IER_RST;
    end else if (wr_ier) begin
      ier_reg <= reg_wdata_i[REG_W-1:0] & IRQ_WMASK;
    end
  end

  // Interrupt core routing register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      iem_reg <= IEM_RST;
    end else if (wr_iem) begin
      iem_reg <= reg_wdata_i[REG_W-1:0] & IRQ_WMASK;
    end
  end

  // Ideal ratio registers for pair A
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ideal_ratio_high_a_reg <= IDHI_RST[IDHI_W-1:0];
    end else if (wr_idhi) begin
      ideal_ratio_high_a_reg <= reg_wdata_i[IDHI_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ideal_ratio_low_a_reg <= IDLO_RST[IDLO_W-1:0];
    end else if (wr_idlo) begin
      ideal_ratio_low_a_reg <= reg_wdata_i[IDLO_W-1:0];
    end
  end

  assign ideal_ratio_a = RATIO_W'({ideal_ratio_high_a_reg, ideal_ratio_low_a_reg});

  // Ratio source: the ideal select bit has no effect unless use ratio is set.
  // Filter pre/post modes are not steered here; software sets them.
  always_comb begin
    ratio_src_next = RS_OFF;
    ratio_next = '0;
    if (use_ratio_a) begin
      if (ideal_ratio_sel_a) begin
        ratio_src_next = RS_IDEAL;
        ratio_next = ideal_ratio_a;
      end else begin
        ratio_src_next = RS_MEASURED;
        ratio_next = measured_ratio_a_i;
      end
    end
  end

  // Registered so the datapath sees a glitch-free ratio
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ratio_src_reg <= RS_OFF;
      ratio_reg <= '0;
    end else begin
      ratio_src_reg <= ratio_src_next;
      ratio_reg <= ratio_next;
    end
  end

  assign ratio_a_src_o = ratio_src_reg;
  assign ratio_a_o = ratio_reg;

  // Enables to the datapath. Pairs run only under the global enable, and
  // everything is held off while the soft reset is in progress.
  assign converter_enable_o = converter_enable && !soft_reset_trigger_busy;
  assign pair_a_enable_o = converter_enable_o && pair_a_enable;
  assign pair_b_enable_o = converter_enable_o && pair_b_enable;
  assign pair_c_enable_o = converter_enable_o && pair_c_enable;
  assign soft_rst_o = soft_reset_trigger_busy;

  // Per-source gating and routing to the two cores
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_SRC_N; gi = gi + 1) begin : g_route
      // Bits 7, 6, 5..3 and 2..0 each gate their own source
      assign irq_gated[gi] = irq_src_i[gi] && ier_reg[gi];
      // Route bit low sends to core 1, high to core 2
      assign irq_to_core1[gi] = irq_gated[gi] && !iem_reg[gi];
      assign irq_to_core2[gi] = irq_gated[gi] && iem_reg[gi];
    end
  endgenerate

  // One flop stage on each line to keep the core inputs clean
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_core1_reg <= 1'b0;
      irq_core2_reg <= 1'b0;
    end else begin
      irq_core1_reg <= |irq_to_core1;
      irq_core2_reg <= |irq_to_core2;
    end
  end

  assign irq_core1_o = irq_core1_reg;
  assign irq_core2_o = irq_core2_reg;

  // Read mux. Unmapped addresses and reserved bits read as zero.
  always_comb begin
    rdata_next = '0;
    unique case (reg_addr_i)
      CTRL_OFS: begin
        rdata_next[REG_W-1:0] = ctrl_reg;
        rdata_next[SOFT_RESET_TRIGGER_BIT] = soft_reset_trigger_busy;
      end
      IER_OFS: begin
        rdata_next[REG_W-1:0] = ier_reg;
      end
      IEM_OFS: begin
        rdata_next[REG_W-1:0] = iem_reg;
      end
      IDHI_OFS: begin
        rdata_next[IDHI_W-1:0] = ideal_ratio_high_a_reg;
      end
      IDLO_OFS: begin
        rdata_next[IDLO_W-1:0] = ideal_ratio_low_a_reg;
      end
      SRC_OFS: begin
        // Raw pending sources, before enable gating
        rdata_next[IRQ_SRC_N-1:0] = irq_src_i;
      end
      REQ_OFS: begin
        // Lower byte: requests routed to core 1; next byte: core 2
        rdata_next[IRQ_SRC_N-1:0] = irq_to_core1;
        rdata_next[2*IRQ_SRC_N-1:IRQ_SRC_N] = irq_to_core2;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_reg <= '0;
    end else if (reg_rd_i) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata_o = rdata_reg;

  // The done pulse of the sequencer is only informative; the busy level
  // already covers the bit readback and the datapath reset.
  logic soft_reset_trigger_done_seen_reg;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      soft_reset_trigger_done_seen_reg <= 1'b0;
    end else if (soft_reset_trigger_done) begin
      // The end of a sequence wins over a clear that lands in the same cycle
      soft_reset_trigger_done_seen_reg <= 1'b1;
    end else if (soft_reset_trigger_start) begin
      soft_reset_trigger_done_seen_reg <= 1'b0;
    end
  end

endmodule : rcc_ctrl_irq

// >>> rcc_ctrl_irq_monitor.sv
// Checker for the rate converter control and interrupt routing bank.
// Sees only the top-level ports; bound in from the testbench.
`timescale 1ns/1ps
module rcc_ctrl_irq_monitor
  import rcc_pkg::*;
#(
  parameter int RATIO_W = 32
)
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [BUS_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [BUS_W-1:0] reg_rdata_o,
  input wire logic [RATIO_W-1:0] measured_ratio_a_i,
  input wire logic [IRQ_SRC_N-1:0] irq_src_i,
  input wire logic converter_enable_o,
  input wire logic pair_a_enable_o,
  input wire logic pair_b_enable_o,
  input wire logic pair_c_enable_o,
  input wire logic soft_rst_o,
  input wire logic [2:0] ratio_a_src_o,
  input wire logic [RATIO_W-1:0] ratio_a_o,
  input wire logic irq_core1_o,
  input wire logic irq_core2_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  logic ctrl_wr;
  assign ctrl_wr = reg_wr_i && reg_addr_i == CTRL_OFS;

  soft_reset_trigger_start_a: assert property (
    ctrl_wr && reg_wdata_i[SOFT_RESET_TRIGGER_BIT] && !soft_rst_o |=> soft_rst_o) else $error("no soft reset");
  soft_reset_trigger_len_a: assert property (
    $rose(soft_rst_o) |-> ##1 soft_rst_o [*8] ##1 !soft_rst_o) else $error("soft reset length");
  soft_reset_trigger_gate_a: assert property (
    soft_rst_o |-> !converter_enable_o && !pair_a_enable_o) else $error("enable in soft reset");
  pair_gate_a: assert property (
    pair_a_enable_o || pair_b_enable_o || pair_c_enable_o |-> converter_enable_o)
    else $error("pair without global");
  ctrl_out_a: assert property (
    ctrl_wr && !reg_wdata_i[SOFT_RESET_TRIGGER_BIT] && !soft_rst_o |=>
    {pair_c_enable_o, pair_b_enable_o, pair_a_enable_o, converter_enable_o} ==
    ($past(reg_wdata_i[0]) ? $past(reg_wdata_i[3:0]) : 4'h0)) else $error("enable mismatch");
  rd_idle_a: assert property (
    !reg_rd_i |=> reg_rdata_o == '0) else $error("read data outside slot");
  irq_quiet_a: assert property (
    irq_src_i == '0 |=> !irq_core1_o && !irq_core2_o) else $error("line without source");
  ratio_hot_a: assert property (
    $onehot(ratio_a_src_o)) else $error("ratio source not one-hot");
  ratio_meas_a: assert property (
    ratio_a_src_o == RS_MEASURED |-> ratio_a_o == $past(measured_ratio_a_i))
    else $error("measured ratio");
  ratio_off_a: assert property (
    ratio_a_src_o == RS_OFF |-> ratio_a_o == '0) else $error("ratio not zero");

  cover property ($rose(soft_rst_o));
  cover property ($rose(irq_core2_o));
  cover property (ratio_a_src_o == RS_IDEAL);
endmodule : rcc_ctrl_irq_monitor

// >>> rcc_core_model.sv
// Two cores receiving interrupt lines; each counts new requests.
// Assumes level requests synchronous to the master clock.
`timescale 1ns/1ps
module rcc_core_model (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic irq_core1_i,
  input wire logic irq_core2_i,
  output logic [15:0] hits1_o,
  output logic [15:0] hits2_o
);
  logic prev1_reg;
  logic prev2_reg;
  // A level request is taken once, as a handler would
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      prev1_reg <= 1'b0;
      prev2_reg <= 1'b0;
      hits1_o <= 16'h0;
      hits2_o <= 16'h0;
    end else begin
      prev1_reg <= irq_core1_i;
      prev2_reg <= irq_core2_i;
      if (irq_core1_i && !prev1_reg) hits1_o <= hits1_o + 16'h1;
      if (irq_core2_i && !prev2_reg) hits2_o <= hits2_o + 16'h1;
    end
  end
endmodule : rcc_core_model

// >>> rcc_ctrl_irq_tb.sv
// Self-checking bench for the control and interrupt routing bank.
// Drives the register port and sources; a core model counts requests.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error at %0t: got %h, expected %h", $time, g, e); end end
module rcc_ctrl_irq_tb
  import rcc_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [BUS_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [BUS_W-1:0] reg_rdata_o;
  logic [31:0] measured_ratio_a_i = 32'h12345678;
  logic [IRQ_SRC_N-1:0] irq_src_i = '0;
  logic converter_enable_o;
  logic pair_a_enable_o;
  logic pair_b_enable_o;
  logic pair_c_enable_o;
  logic soft_rst_o;
  logic [2:0] ratio_a_src_o;
  logic [31:0] ratio_a_o;
  logic irq_core1_o;
  logic irq_core2_o;
  logic [15:0] hits1;
  logic [15:0] hits2;
  logic [3:0] en_vec;
  assign en_vec = {pair_c_enable_o, pair_b_enable_o, pair_a_enable_o, converter_enable_o};
  logic [7:0] offs [6] = '{CTRL_OFS, IER_OFS, IEM_OFS, IDHI_OFS, IDLO_OFS, 8'h1c};
  logic [2:0] rsrc [4] = '{3'b001, 3'b001, 3'b010, 3'b100};
  logic [31:0] rval [4] = '{32'h0, 32'h0, 32'h12345678, 32'habcdef01};
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  int soft_reset_trigger_cyc = 0;

  rcc_ctrl_irq #(.RATIO_W(32)) DUT (.*);
  rcc_core_model cores (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .irq_core1_i(irq_core1_o), .irq_core2_i(irq_core2_o), .hits1_o(hits1), .hits2_o(hits2));

  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // Timeout ceiling well above the roughly 380 cycles the tests need
  always @(posedge clk_sys_i) begin
    cycles++;
    if (soft_rst_o) soft_reset_trigger_cyc++;
    if (cycles == 4000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e)
  endtask : rd

  task automatic src(input logic [7:0] v);
    @(posedge clk_sys_i);
    irq_src_i <= v;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : src

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(offs[i], 32'h0);
    $display("Test reset values done");
    wr(CTRL_OFS, 32'hffefef);
    rd(CTRL_OFS, 32'h00600f);
    // Reserved enable bits stay zero, as software must keep them
    wr(IER_OFS, 32'h0000ff);
    rd(IER_OFS, 32'h0000ff);
    for (int b = 1; b < 4; b++) begin
      wr(CTRL_OFS, 32'h1 | (32'h1 << b));
      `CHK(en_vec[3:1], 3'(1 << (b - 1)))
    end
    wr(CTRL_OFS, 32'h0e);
    `CHK(en_vec, 4'h0)
    wr(CTRL_OFS, 32'h0f);
    `CHK(en_vec, 4'hf)
    $display("Test enables done");
    soft_reset_trigger_cyc = 0;
    wr(CTRL_OFS, 32'h1f);
    `CHK(en_vec, 4'h0)
    rd(CTRL_OFS, 32'h1f);
    // A second start while busy must not stretch the count
    wr(CTRL_OFS, 32'h1f);
    repeat (12) @(posedge clk_sys_i);
    #1;
    `CHK(soft_reset_trigger_cyc, 9)
    rd(CTRL_OFS, 32'h0f);
    `CHK(en_vec, 4'hf)
    $display("Test soft reset done");
    wr(IDHI_OFS, 32'hab);
    wr(IDLO_OFS, 32'hcdef01);
    for (int i = 0; i < 4; i++) begin
      // Filter modes live elsewhere; software would set them for the ideal case
      wr(CTRL_OFS, 32'(i) << 13);
      src(8'h0);
      `CHK(ratio_a_src_o, rsrc[i])
      `CHK(ratio_a_o, rval[i])
    end
    $display("Test ratio done");
    for (int s = 0; s < 8; s++) begin
      for (int r = 0; r < 2; r++) begin
        wr(IER_OFS, 32'h1 << s);
        wr(IEM_OFS, 32'(r) << s);
        src(8'h1 << s);
        `CHK({irq_core2_o, irq_core1_o}, (r == 1) ? 2'b10 : 2'b01)
        rd(SRC_OFS, 32'h1 << s);
        rd(REQ_OFS, (32'h1 << s) << (8 * r));
        src(8'h0);
        `CHK({irq_core2_o, irq_core1_o}, 2'b00)
      end
      wr(IER_OFS, 32'hff ^ (32'h1 << s));
      src(8'h1 << s);
      `CHK({irq_core2_o, irq_core1_o}, 2'b00)
      src(8'h0);
    end
    `CHK(hits1, 16'h8)
    `CHK(hits2, 16'h8)
    $display("Test interrupt routing done");
    give_verdict();
  end
endmodule : rcc_ctrl_irq_tb

bind rcc_ctrl_irq rcc_ctrl_irq_monitor #(.RATIO_W(RATIO_W)) mon (.*);
